// [hdl/itf_top.sv]
`timescale 1ns/1ps
`include "itf_cfg.svh"
// Operation
// - Activation loads the 32-bit counter from preload and ticks it down.
// - At zero the timer flags an enabled interrupt and reloads itself.
// - A control bit picks prescaled clock or time base as tick source.
// - Prescaled rate codes 00..11 give 8, 4, 2 and 1 MHz ticks.
// - Time base rate codes 00..11 give 100 ns, 1 us, 1 ms and 1 s ticks.
// - Each expiry can trigger a multiple channel read.
// - Each debounced digital input can interrupt on a chosen edge.
// - Each digital input serves as general input or counter reference.
// - All inputs pass a three-stage debounce, sampled every 6 cycles, 33.3 MHz, where advanced debounce is off.
// - Advanced debounce samples the same filter at a slower base.
// - Encoder and digital inputs have own advanced settings per channel.
module itf_top #(
    parameter logic [31:0] TB_MS_CYC = 32'(`ITF_TB2_CYC),
    parameter logic [31:0] TB_S_CYC = 32'(`ITF_TB3_CYC)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire itf_pkg::itf_apb_req_type apbReq,
    output itf_pkg::itf_apb_rsp_type apbRsp,
    input wire logic [5:0] encAPin,
    input wire logic [5:0] encBPin,
    input wire logic [5:0] encIPin,
    input wire logic [5:0] digPin,
    output logic [5:0] encAFilt,
    output logic [5:0] encBFilt,
    output logic [5:0] encIFilt,
    output logic [5:0] gpInput,
    output logic [5:0] refInput,
    output logic mcrTrigger,
    output logic irq
);
    itf_pkg::itf_tctrl_type ctrl_q;
    itf_pkg::itf_edge_type edge_q;
    itf_pkg::itf_dbcfg_type dbEnc_q;
    itf_pkg::itf_dbcfg_type dbDig_q;
    itf_pkg::itf_tstate_type state_q;
    logic [31:0] preload_q;
    logic [31:0] count_q;
    logic [31:0] tmrDiv_q;
    logic [31:0] dbFast_q;
    logic [31:0] dbEncCnt_q;
    logic [31:0] dbDigCnt_q;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] mask_q;
    logic [31:0] rdata_q;
    logic [5:0] refSel_q;
    logic [5:0] digPrev_q;
    logic [5:0] gp_q;
    logic [5:0] ref_q;
    logic [5:0] digFilt;
    logic [5:0] digEvent;
    logic [31:0] tmrLast;
    logic [31:0] statusSet;
    logic [31:0] statusClr;
    logic [31:0] rdMux;
    logic mapped;
    logic setupCyc;
    logic wrEn;
    logic rdEn;
    logic tick;
    logic expiry;
    logic fastTick;
    logic encSlow;
    logic digSlow;
    logic mcr_q;
    logic irq_q;

    // counter step with wrap; >= keeps it safe when the limit shrinks
    function automatic logic [31:0] nextWrap(
        input logic [31:0] cnt,
        input logic [31:0] last
    );
        nextWrap = (cnt >= last) ? 32'h0000_0000 : cnt + 32'h0000_0001;
    endfunction

    // tick period in system cycles for source and rate code
    function automatic logic [31:0] tmrPeriod(
        input logic src,
        input logic [1:0] rate
    );
        logic [31:0] p;
        p = 32'h0000_0001;
        if (!src) begin
            case (rate)
                2'h0: p = 32'(`ITF_PS0_CYC);
                2'h1: p = 32'(`ITF_PS1_CYC);
                2'h2: p = 32'(`ITF_PS2_CYC);
                default: p = 32'(`ITF_PS3_CYC);
            endcase
        end else begin
            case (rate)
                2'h0: p = 32'(`ITF_TB0_CYC);
                2'h1: p = 32'(`ITF_TB1_CYC);
                2'h2: p = TB_MS_CYC;
                default: p = TB_S_CYC;
            endcase
        end
        tmrPeriod = p;
    endfunction

    function automatic logic isAddr(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        isAddr = (addr == ofs);
    endfunction

    // apb decode; one wait-free access, data captured in setup
    assign setupCyc = ce && apbReq.psel && !apbReq.penable;
    assign wrEn = ce && apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign rdEn = ce && apbReq.psel && apbReq.penable && !apbReq.pwrite;
    assign apbRsp.pready = ce;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
    assign apbRsp.prdata = rdata_q;

    // read mux, reserved bits come back as zero
    always_comb begin
        rdMux = 32'h0000_0000;
        mapped = 1'b1;
        case (apbReq.paddr)
            `ITF_OFS_CTRL: rdMux = ctrl_q;
            `ITF_OFS_PRELOAD: rdMux = preload_q;
            `ITF_OFS_COUNT: rdMux = count_q;
            `ITF_OFS_STATUS: rdMux = status_q;
            `ITF_OFS_MASK: rdMux = mask_q;
            `ITF_OFS_EDGE: rdMux = edge_q;
            `ITF_OFS_DBENC: rdMux = dbEnc_q;
            `ITF_OFS_DBDIG: rdMux = dbDig_q;
            `ITF_OFS_INPUTS: begin
                rdMux[`ITF_IN_DIG_LSB +: 6] = digFilt;
                rdMux[`ITF_IN_ENCA_LSB +: 6] = encAFilt;
                rdMux[`ITF_IN_ENCB_LSB +: 6] = encBFilt;
                rdMux[`ITF_IN_ENCI_LSB +: 6] = encIFilt;
            end
            `ITF_OFS_REFSEL: rdMux = {26'h0, refSel_q};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `ITF_RST_WORD;
        end else if (setupCyc) begin
            rdata_q <= rdMux;
        end
    end

    // software writable configuration
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `ITF_RST_WORD;
            preload_q <= `ITF_RST_WORD;
            mask_q <= `ITF_RST_WORD;
            edge_q <= `ITF_RST_WORD;
            dbEnc_q <= `ITF_RST_WORD;
            dbDig_q <= `ITF_RST_WORD;
            refSel_q <= `ITF_RST_CH;
        end else if (wrEn) begin
            if (isAddr(apbReq.paddr, `ITF_OFS_CTRL)) begin
                ctrl_q <= apbReq.pwdata & 32'h0000_0137;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_PRELOAD)) begin
                preload_q <= apbReq.pwdata;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_MASK)) begin
                mask_q <= apbReq.pwdata & 32'h0000_3F01;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_EDGE)) begin
                edge_q <= apbReq.pwdata & 32'h0000_3F3F;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_DBENC)) begin
                dbEnc_q <= apbReq.pwdata & 32'hFFFF_003F;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_DBDIG)) begin
                dbDig_q <= apbReq.pwdata & 32'hFFFF_003F;
            end
            if (isAddr(apbReq.paddr, `ITF_OFS_REFSEL)) begin
                refSel_q <= apbReq.pwdata[5:0];
            end
        end
    end

    // timer sequencing: idle until active, one load cycle, then run
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= itf_pkg::TS_IDLE;
        end else if (ce) begin
            case (state_q)
                itf_pkg::TS_IDLE: begin
                    if (ctrl_q.active) begin
                        state_q <= itf_pkg::TS_LOAD;
                    end
                end
                itf_pkg::TS_LOAD: begin
                    state_q <= ctrl_q.active ? itf_pkg::TS_RUN
                                             : itf_pkg::TS_IDLE;
                end
                itf_pkg::TS_RUN: begin
                    if (!ctrl_q.active) begin
                        state_q <= itf_pkg::TS_IDLE;
                    end
                end
                default: state_q <= itf_pkg::TS_IDLE;
            endcase
        end
    end

    // tick source; prescaler restarts on load so the first interval is full
    assign tmrLast = tmrPeriod(ctrl_q.srcSel, ctrl_q.rate) - 32'h0000_0001;
    assign tick = ce && (state_q == itf_pkg::TS_RUN)
                  && (tmrDiv_q >= tmrLast);
    assign expiry = tick && (count_q <= 32'h0000_0001);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tmrDiv_q <= `ITF_RST_WORD;
        end else if (ce) begin
            if (state_q == itf_pkg::TS_RUN) begin
                tmrDiv_q <= nextWrap(tmrDiv_q, tmrLast);
            end else begin
                tmrDiv_q <= 32'h0000_0000;
            end
        end
    end

    // down counter; reaching zero reloads instead of holding zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= `ITF_RST_WORD;
        end else if (ce) begin
            if (state_q == itf_pkg::TS_LOAD) begin
                count_q <= preload_q;
            end else if (expiry) begin
                count_q <= preload_q;
            end else if (tick) begin
                count_q <= count_q - 32'h0000_0001;
            end
        end
    end

    // read trigger pulse toward the channel logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mcr_q <= 1'b0;
        end else if (ce) begin
            mcr_q <= expiry && ctrl_q.mcrEn;
        end
    end
    assign mcrTrigger = mcr_q;

    // debounce time bases: fast default, slow multiples per group
    assign fastTick = ce && (dbFast_q >= 32'(`ITF_DB_FAST_CYC - 1));
    assign encSlow = fastTick && (dbEncCnt_q >= {16'h0000, dbEnc_q.div});
    assign digSlow = fastTick && (dbDigCnt_q >= {16'h0000, dbDig_q.div});

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbFast_q <= `ITF_RST_WORD;
            dbEncCnt_q <= `ITF_RST_WORD;
            dbDigCnt_q <= `ITF_RST_WORD;
        end else if (ce) begin
            dbFast_q <= nextWrap(dbFast_q, 32'(`ITF_DB_FAST_CYC - 1));
            if (fastTick) begin
                dbEncCnt_q <= nextWrap(dbEncCnt_q, {16'h0000, dbEnc_q.div});
                dbDigCnt_q <= nextWrap(dbDigCnt_q, {16'h0000, dbDig_q.div});
            end
        end
    end

    // one filter per signal group, encoder signals share a channel enable
    itf_debounce u_dbEncA (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pinIn(encAPin),
        .fastTick(fastTick), .slowTick(encSlow), .advEn(dbEnc_q.advEn),
        .filtOut(encAFilt)
    );
    itf_debounce u_dbEncB (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pinIn(encBPin),
        .fastTick(fastTick), .slowTick(encSlow), .advEn(dbEnc_q.advEn),
        .filtOut(encBFilt)
    );
    itf_debounce u_dbEncI (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pinIn(encIPin),
        .fastTick(fastTick), .slowTick(encSlow), .advEn(dbEnc_q.advEn),
        .filtOut(encIFilt)
    );
    itf_debounce u_dbDig (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .pinIn(digPin),
        .fastTick(fastTick), .slowTick(digSlow), .advEn(dbDig_q.advEn),
        .filtOut(digFilt)
    );

    // edge detect on filtered digital inputs
    assign digEvent = edge_q.edgeEn
        & ((edge_q.fallSel & digPrev_q & ~digFilt)
           | (~edge_q.fallSel & ~digPrev_q & digFilt));

    // digital input role and edge history
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            digPrev_q <= `ITF_RST_CH;
            gp_q <= `ITF_RST_CH;
            ref_q <= `ITF_RST_CH;
        end else if (ce) begin
            digPrev_q <= digFilt;
            gp_q <= digFilt & ~refSel_q;
            ref_q <= digFilt & refSel_q;
        end
    end
    assign gpInput = gp_q;
    assign refInput = ref_q;

    // sticky status; read clears only what was read, so a set wins
    always_comb begin
        statusSet = 32'h0000_0000;
        statusSet[`ITF_ST_TMR_BIT] = expiry && ctrl_q.irqEn;
        statusSet[`ITF_ST_DIG_LSB +: 6] = digEvent;
        statusClr = (rdEn && isAddr(apbReq.paddr, `ITF_OFS_STATUS))
                    ? rdata_q : 32'h0000_0000;
        status_d = (status_q & ~statusClr) | statusSet;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= `ITF_RST_WORD;
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end
    assign irq = irq_q;

    property p_load;
        @(posedge sys_clk) disable iff (!nrst)
        (ce && state_q == itf_pkg::TS_LOAD) |=> count_q == $past(preload_q);
    endproperty
    a_load: assert property (p_load)
        else $error("counter not loaded from preload on activation");

    property p_reload;
        @(posedge sys_clk) disable iff (!nrst)
        (tick && count_q <= 32'h0000_0001) |=> count_q == $past(preload_q);
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter did not reload at zero");

    property p_tmr_irq;
        @(posedge sys_clk) disable iff (!nrst)
        (expiry && ctrl_q.irqEn) |=> status_q[`ITF_ST_TMR_BIT] ##1 irq_q
            || !mask_q[`ITF_ST_TMR_BIT] || !ce;
    endproperty
    a_tmr_irq: assert property (p_tmr_irq)
        else $error("timer expiry did not set its status bit");

    property p_ps_rate;
        @(posedge sys_clk) disable iff (!nrst)
        (tick && !ctrl_q.srcSel && ctrl_q.rate == 2'h0 && tmrDiv_q != 0)
            |=> !tick [*8];
    endproperty
    a_ps_rate: assert property (p_ps_rate)
        else $error("prescaled ticks too close together");

    property p_tb_rate;
        @(posedge sys_clk) disable iff (!nrst)
        (tick && ctrl_q.srcSel && ctrl_q.rate == 2'h0 && tmrDiv_q != 0)
            |=> !tick [*8];
    endproperty
    a_tb_rate: assert property (p_tb_rate)
        else $error("time base ticks too close together");

    property p_mcr;
        @(posedge sys_clk) disable iff (!nrst)
        (expiry && ctrl_q.mcrEn) |=> mcrTrigger;
    endproperty
    a_mcr: assert property (p_mcr)
        else $error("expiry did not trigger a channel read");

    property p_dig_edge;
        @(posedge sys_clk) disable iff (!nrst)
        (ce && edge_q.edgeEn[0] && !edge_q.fallSel[0]
            && $rose(digFilt[0])) |=> status_q[`ITF_ST_DIG_LSB];
    endproperty
    a_dig_edge: assert property (p_dig_edge)
        else $error("digital rising edge lost");

    property p_ref_role;
        @(posedge sys_clk) disable iff (!nrst)
        ce |=> (refInput & gpInput) == 6'h00
            && (refInput | gpInput) == $past(digFilt);
    endproperty
    a_ref_role: assert property (p_ref_role)
        else $error("digital input role split wrong");

    property p_stopped;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == itf_pkg::TS_IDLE) [*2] |-> !mcrTrigger && !expiry
            && $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("stopped timer still active");

endmodule

// [hdl/itf_cfg.svh]
`ifndef ITF_CFG_SVH
`define ITF_CFG_SVH

// system clock rate
`define ITF_CLK_MHZ 200

// prescaled timer clock periods in ns
`define ITF_PS0_NS 125
`define ITF_PS1_NS 250
`define ITF_PS2_NS 500
`define ITF_PS3_NS 1000
`define ITF_PS0_CYC ((`ITF_PS0_NS * `ITF_CLK_MHZ) / 1000)
`define ITF_PS1_CYC ((`ITF_PS1_NS * `ITF_CLK_MHZ) / 1000)
`define ITF_PS2_CYC ((`ITF_PS2_NS * `ITF_CLK_MHZ) / 1000)
`define ITF_PS3_CYC ((`ITF_PS3_NS * `ITF_CLK_MHZ) / 1000)

// time base steps, each in its own unit
`define ITF_TB0_NS 100
`define ITF_TB1_US 1
`define ITF_TB2_MS 1
`define ITF_TB3_S 1
`define ITF_TB0_CYC ((`ITF_TB0_NS * `ITF_CLK_MHZ) / 1000)
`define ITF_TB1_CYC (`ITF_TB1_US * `ITF_CLK_MHZ)
`define ITF_TB2_CYC (`ITF_TB2_MS * `ITF_CLK_MHZ * 1000)
`define ITF_TB3_CYC (`ITF_TB3_S * `ITF_CLK_MHZ * 1000000)

// default debounce sample rate, rounded to sample at least this fast
`define ITF_DB_FS_MHZ 32
`define ITF_DB_FAST_CYC (`ITF_CLK_MHZ / `ITF_DB_FS_MHZ)

// register byte offsets
`define ITF_OFS_CTRL 8'h00
`define ITF_OFS_PRELOAD 8'h04
`define ITF_OFS_COUNT 8'h08
`define ITF_OFS_STATUS 8'h0C
`define ITF_OFS_MASK 8'h10
`define ITF_OFS_EDGE 8'h14
`define ITF_OFS_DBENC 8'h18
`define ITF_OFS_DBDIG 8'h1C
`define ITF_OFS_INPUTS 8'h20
`define ITF_OFS_REFSEL 8'h24

// status and mask field positions
`define ITF_ST_TMR_BIT 0
`define ITF_ST_DIG_LSB 8

// input state field positions
`define ITF_IN_DIG_LSB 0
`define ITF_IN_ENCA_LSB 8
`define ITF_IN_ENCB_LSB 16
`define ITF_IN_ENCI_LSB 24

// reset values
`define ITF_RST_WORD 32'h0000_0000
`define ITF_RST_CH 6'h00

`endif

// [hdl/itf_pkg.sv]
package itf_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } itf_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } itf_apb_rsp_type;

    typedef struct packed {
        logic [22:0] rsvdHi;
        logic mcrEn;
        logic [1:0] rsvdMid;
        logic [1:0] rate;
        logic rsvdLo;
        logic srcSel;
        logic irqEn;
        logic active;
    } itf_tctrl_type;

    typedef struct packed {
        logic [15:0] div;
        logic [9:0] rsvd;
        logic [5:0] advEn;
    } itf_dbcfg_type;

    typedef struct packed {
        logic [17:0] rsvdHi;
        logic [5:0] fallSel;
        logic [1:0] rsvdLo;
        logic [5:0] edgeEn;
    } itf_edge_type;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_LOAD,
        TS_RUN
    } itf_tstate_type;

endpackage

// [hdl/itf_debounce.sv]
`timescale 1ns/1ps
module itf_debounce (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [5:0] pinIn,
    input wire logic fastTick,
    input wire logic slowTick,
    input wire logic [5:0] advEn,
    output logic [5:0] filtOut
);
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [5:0] s0_q;
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [5:0] filt_q;
    logic [5:0] smp;
    logic [5:0] agree;

    // per-bit sample strobe, slow base only where enabled
    assign smp = (advEn & {6{slowTick}}) | (~advEn & {6{fastTick}});
    assign agree = (s0_q & s1_q & s2_q) | ~(s0_q | s1_q | s2_q);
    assign filtOut = filt_q;

    // pins are asynchronous, two flops before any use
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
        end else if (ce) begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    // three-stage sample chain
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s0_q <= 6'h00;
            s1_q <= 6'h00;
            s2_q <= 6'h00;
        end else if (ce) begin
            s0_q <= (s0_q & ~smp) | (sync_q & smp);
            s1_q <= (s1_q & ~smp) | (s0_q & smp);
            s2_q <= (s2_q & ~smp) | (s1_q & smp);
        end
    end

    // output moves only when all stages agree, short glitches die here
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            filt_q <= 6'h00;
        end else if (ce) begin
            filt_q <= (filt_q & ~agree) | (s0_q & agree);
        end
    end

    property p_db_agree;
        @(posedge sys_clk) disable iff (!nrst)
        $changed(filt_q[0]) |->
            ($past(s1_q[0]) == filt_q[0]) && ($past(s2_q[0]) == filt_q[0]);
    endproperty
    a_db_agree: assert property (p_db_agree)
        else $error("filter output moved without agreeing samples");

endmodule

// [bench/itf_pin_model.sv]
`timescale 1ns/1ps
module itf_pin_model (
    input wire logic sys_clk,
    output logic [23:0] pins
);
    // lines rest low: switches open, encoders idle
    initial pins = 24'h000000;

    // step all lines to a new level after an edge
    task automatic drive(input logic [23:0] v);
        @(posedge sys_clk);
        pins <= v;
    endtask

    // contact bounce: a level that holds n cycles, then falls back
    task automatic bounce(input logic [23:0] v, input int n);
        logic [23:0] old;
        old = pins;
        @(posedge sys_clk);
        pins <= v;
        repeat (n) @(posedge sys_clk);
        pins <= old;
    endtask
endmodule

// [bench/itf_top_tb.sv]
`timescale 1ns/1ps
module itf_top_tb;
    logic sysClk;
    logic nrst;
    logic ce;
    itf_pkg::itf_apb_req_type req;
    itf_pkg::itf_apb_rsp_type rsp;
    logic [23:0] pins;
    logic [5:0] encA, encB, encI, gp, refIn;
    logic mcrTrigger, irq;
    logic [31:0] rdat, seed;
    logic rerr;
    logic seenClr;
    logic [5:0] seenDig, seenEnc;
    int failCount, checks, pre, per, pulses;
    int psNs[4] = '{125, 250, 500, 1000};
    int tbCyc[4] = '{20, 200, 40, 80};

    itf_top #(.TB_MS_CYC(32'd40), .TB_S_CYC(32'd80)) u_itf_top (
        .sys_clk(sysClk), .nrst(nrst), .ce(ce), .apbReq(req),
        .apbRsp(rsp), .encAPin(pins[11:6]), .encBPin(pins[17:12]),
        .encIPin(pins[23:18]), .digPin(pins[5:0]), .encAFilt(encA),
        .encBFilt(encB), .encIFilt(encI), .gpInput(gp),
        .refInput(refIn), .mcrTrigger(mcrTrigger), .irq(irq));
    itf_pin_model u_itf_pin_model (.sys_clk(sysClk), .pins(pins));

    // 200 MHz system clock
    initial begin
        sysClk = 1'b0;
        forever #2.5 sysClk = ~sysClk;
    end

    // filtered levels seen at any time, to catch short passes
    always @(negedge sysClk) begin
        if (seenClr) begin
            seenDig <= 6'h00;
            seenEnc <= 6'h00;
        end else begin
            seenDig <= seenDig | gp | refIn;
            seenEnc <= seenEnc | encA | encB | encI;
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sysClk);
        req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
        @(posedge sysClk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        // a slave that never answers counts as a mismatch
        if (rsp.pready !== 1'b1) failCount++;
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // spacing of two trigger pulses, in cycles
    task automatic measure(input int exp);
        int n;
        n = 0;
        while (mcrTrigger !== 1'b1 && n < 3000) begin
            @(negedge sysClk);
            n++;
        end
        n = 0;
        do begin
            @(negedge sysClk);
            n++;
        end while (mcrTrigger !== 1'b1 && n < 3000);
        check(32'(n), 32'(exp));
    endtask

    task automatic report_and_stop();
        if (failCount == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog: whole run needs well under this many cycles
    initial begin
        repeat (40000) @(posedge sysClk);
        failCount++;
        report_and_stop();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        req = '0;
        seenClr = 1'b0;
        seed = 32'h6F4E;
        failCount = 0;
        checks = 0;
        repeat (6) @(posedge sysClk);
        nrst <= 1'b1;
        // read-only and unmapped places refuse writes
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        apb(1'b1, 8'h30, 32'hFFFFFFFF);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rdat, 32'h0);
        foreach (psNs[i]) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(rdat, 32'h0);
        end
        // reserved control bits read back as zero
        apb(1'b1, 8'h00, 32'hFFFFFFFE);
        apb(1'b0, 8'h00, 32'h0);
        check(rdat, 32'h00000136);
        apb(1'b1, 8'h10, 32'h1);
        // every source and rate, random preload
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 4; r++) begin
                pre = 1 + int'(rnd() % 4);
                per = (s == 1) ? tbCyc[r] : psNs[r] / 5;
                apb(1'b1, 8'h04, 32'(pre));
                apb(1'b1, 8'h00, 32'h0);
                apb(1'b1, 8'h00, 32'h103 | 32'(s << 2) | 32'(r << 4));
                measure(pre * per);
            end
        end
        check({31'h0, irq}, 32'h1);
        // stopped timer: frozen count, no triggers
        apb(1'b1, 8'h00, 32'h102);
        apb(1'b0, 8'h0C, 32'h0);
        check(rdat & 32'h1, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        pre = int'(rdat);
        pulses = 0;
        repeat (400) begin
            @(negedge sysClk);
            if (mcrTrigger === 1'b1) pulses++;
        end
        check(32'(pulses), 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check(rdat, 32'(pre));
        check({31'h0, irq}, 32'h0);
        // ch0 rising, ch1 falling; ch1 used as reference
        apb(1'b1, 8'h14, 32'h203);
        apb(1'b1, 8'h10, 32'h300);
        apb(1'b1, 8'h24, 32'h2);
        // clock enable low freezes the filters, so nothing may pass
        ce <= 1'b0;
        u_itf_pin_model.drive(24'h000003);
        repeat (60) @(posedge sysClk);
        check({26'h0, gp}, 32'h0);
        check({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        repeat (60) @(posedge sysClk);
        check({26'h0, gp}, 32'h1);
        check({26'h0, refIn}, 32'h2);
        apb(1'b0, 8'h20, 32'h0);
        check(rdat, 32'h3);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        check(rdat, 32'h100);
        u_itf_pin_model.drive(24'h000000);
        repeat (60) @(posedge sysClk);
        apb(1'b0, 8'h0C, 32'h0);
        check(rdat, 32'h200);
        // one-cycle glitch never reaches the outputs
        seenClr <= 1'b1;
        @(posedge sysClk);
        seenClr <= 1'b0;
        u_itf_pin_model.bounce(24'hFFFFFF, 1);
        repeat (60) @(posedge sysClk);
        check({20'h0, seenDig, seenEnc}, 32'h0);
        // slow sampling only on encoder ch0 and digital ch1
        apb(1'b1, 8'h18, 32'h00030001);
        apb(1'b1, 8'h1C, 32'h00030002);
        seenClr <= 1'b1;
        @(posedge sysClk);
        seenClr <= 1'b0;
        u_itf_pin_model.bounce(24'hFFFFFF, 40);
        repeat (150) @(posedge sysClk);
        check({26'h0, seenDig}, 32'h3D);
        check({26'h0, seenEnc}, 32'h3E);
        report_and_stop();
    end
endmodule
